// ---- verilog/scan_select_pkg.sv ----
// Package for the converter input selection and scan sequencing block.
// Assumes a single 10 MHz core clock and an AHB-Lite register port.
package scan_select_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [1:0] conversion_setup_idx = 2'h0;
  localparam logic [1:0] interface_setup_idx = 2'h1;
  localparam logic [7:0] conversion_setup_addr = 8'h00;
  localparam logic [7:0] interface_setup_addr = 8'h04;
  // Status register of our own, read-only view of the selection logic.
  localparam logic [7:0] selection_status_addr = 8'h08;
  localparam logic [7:0] addr_mask = 8'hfc;

  // Field positions of the first register.
  localparam int vref_bit = 0;
  localparam int mode_bit = 1;
  localparam int powerdown_bit = 2;
  localparam int channel_pick_lo = 3;
  localparam int channel_pick_hi = 4;
  localparam int differential_count_lo = 5;
  localparam int differential_count_hi = 6;
  localparam int autoscan_bit = 7;
  localparam int selftest_pick_lo = 8;
  localparam int selftest_pick_hi = 9;

  // Field positions of the second register.
  localparam int device_reset_bit = 0;
  localparam int overflow_or_fifo_clear = 1;
  localparam int fill_level_lo = 2;
  localparam int fill_level_hi = 3;
  localparam int ready_type_bit = 4;
  localparam int ready_polarity_bit = 5;
  localparam int strobe_mode_bit = 6;
  localparam int output_coding_select = 7;
  localparam int offset_bit = 8;
  localparam int reserved_bit = 9;

  // Reset values (differential_count_lo set, ready type and polarity set).
  localparam logic [9:0] conversion_setup_rst = 10'h020;
  localparam logic [9:0] interface_setup_rst = 10'h030;

  // Delay from a device reset to the first stored result.
  localparam int first_result_clocks = 5;
  localparam logic [2:0] first_result_cnt = 3'(first_result_clocks);

  // Converted source, one code per analog selection.
  typedef enum logic [2:0] {
    src_a_pos, src_a_neg, src_b_pos, src_b_neg, src_a_diff, src_b_diff, src_none
  } source_e;

  // Test source codes.
  localparam logic [1:0] test_normal = 2'h0;
  localparam logic [1:0] test_upper_ref = 2'h1;
  localparam logic [1:0] test_mid_ref = 2'h2;
  localparam logic [1:0] test_lower_ref = 2'h3;

  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
endpackage

// ---- verilog/scan_sequencer.sv ----
// Sequencer that steps through the inputs of one configuration code.
// Assumes conv_step pulses once per conversion and restart on config writes.
`timescale 1ns/1ps
module scan_sequencer
  import scan_select_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [4:0] config_code, // Scan, differential and channel bits.
  input wire logic conv_step, // One pulse per finished conversion.
  input wire logic restart, // Return to the first input.
  output source_e source, // Input selected now.
  output logic [1:0] position, // Position within the sequence.
  output logic reserved_code // Code is outside the defined set.
);
  logic [1:0] pos_q;
  logic [1:0] pos_d;
  logic [1:0] last_pos;
  logic scan_on;
  logic [1:0] diff_bits;
  logic [1:0] chan;
  source_e pick;
  logic bad;

  assign scan_on = config_code[4];
  assign diff_bits = config_code[3:2];
  assign chan = config_code[1:0];

  // Decode the selected input for each code and sequence position.
  always_comb begin
    pick = src_none;
    last_pos = 2'h0;
    bad = 1'b0;
    if (!scan_on) begin
      unique case (diff_bits)
        2'h0: pick = source_e'({1'b0, chan});
        2'h1: begin
          if (chan == 2'h0) pick = src_a_diff;
          else if (chan == 2'h1) pick = src_b_diff;
          else bad = 1'b1;
        end
        default: bad = 1'b1;
      endcase
    end else begin
      // Scan needs more than one input, so channel code zero is refused.
      unique case ({diff_bits, chan})
        4'h1, 4'h2, 4'h3: begin
          last_pos = chan;
          pick = source_e'({1'b0, pos_q});
        end
        4'h5: begin
          last_pos = 2'h1;
          pick = (pos_q == 2'h0) ? src_a_pos : src_b_diff;
        end
        4'h6: begin
          last_pos = 2'h2;
          pick = (pos_q == 2'h2) ? src_b_diff : source_e'({1'b0, pos_q});
        end
        4'h9: begin
          last_pos = 2'h1;
          pick = (pos_q == 2'h0) ? src_a_diff : src_b_diff;
        end
        default: bad = 1'b1;
      endcase
    end
  end

  // Advance once per conversion and wrap after the last input.
  always_comb begin
    pos_d = pos_q;
    if (restart || !scan_on || bad) pos_d = 2'h0;
    else if (conv_step) pos_d = (pos_q == last_pos) ? 2'h0 : pos_q + 2'h1;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) pos_q <= 2'h0;
    else pos_q <= pos_d;
  end

  assign source = pick;
  assign position = pos_q;
  assign reserved_code = bad;
endmodule

// ---- verilog/adc_input_scan_select.sv ----
// Top of the converter input selection block with its AHB-Lite register port.
// Assumes conv_done pulses for one core clock per finished conversion.
`timescale 1ns/1ps

// Behaviour
// - Input configuration taken from bits three to seven.
// - Plain codes pick one single-ended input.
// - Low differential bit picks A or B pair.
// - Scan needs more than one input.
// - Single-ended scan of two, three, four inputs.
// - Scan alternates A positive and B pair.
// - Scan both A inputs, then B pair.
// - Scan alternates A pair and B pair.
// - Test bits select normal or reference sources.
// - Second register at index one, write only.
// - Second register field layout from bit zero.
// - Test mode suppresses results ready indication.
// - Reset bit restores defaults; first result later.
module adc_input_scan_select
  import scan_select_pkg::*;
(
  input wire logic core_clk, // Core clock, 10 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [7:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic hready, // Bus ready in.
  input wire logic [31:0] hwdata, // Write data.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  input wire logic conv_done, // One pulse per conversion.
  input wire logic fifo_level_hit, // FIFO trigger level reached.
  output scan_select_pkg::source_e input_select, // Analog input in use.
  output logic [1:0] test_select, // Test source code.
  output logic [9:0] conversion_setup, // First register contents.
  output logic [9:0] interface_setup, // Second register contents.
  output logic fifo_clear, // Pulse clearing the FIFO pointer.
  output logic offset_clear, // Pulse clearing the offset register.
  output logic store_enable, // Results may be stored.
  output logic results_ready // Results ready, type and polarity applied.
);
  logic [9:0] conv_q;
  logic [9:0] conv_d;
  logic [9:0] intf_q;
  logic [9:0] intf_d;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [2:0] hold_q;
  logic fifo_clear_q;
  logic offset_clear_q;
  logic store_q;
  logic ready_q;
  logic ready_seen_q;
  source_e sel_q;
  logic [1:0] test_q;
  logic [4:0] code;
  source_e seq_source;
  logic [1:0] seq_pos;
  logic seq_bad;
  logic addr_phase;
  logic wr_conv;
  logic wr_intf;
  logic dev_reset;
  logic restart_seq;
  logic ready_level;
  logic ready_pulse;
  logic ready_pin;
  logic [31:0] rd_value;

  // Address phase decode; only whole-word transfers are taken.
  assign addr_phase = hsel && hready && (htrans == htrans_nonseq) && (hsize == hsize_word);
  assign wr_conv = wr_pend_q && ((wr_addr_q & addr_mask) == conversion_setup_addr);
  assign wr_intf = wr_pend_q && ((wr_addr_q & addr_mask) == interface_setup_addr);
  assign dev_reset = wr_intf && hwdata[device_reset_bit];
  assign restart_seq = wr_conv || dev_reset;

  // Capture the address phase so the data phase can complete next cycle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Register writes; a device reset returns both registers to defaults.
  always_comb begin
    conv_d = conv_q;
    intf_d = intf_q;
    if (dev_reset) begin
      conv_d = conversion_setup_rst;
      intf_d = interface_setup_rst;
    end else begin
      if (wr_conv) conv_d = hwdata[9:0];
      if (wr_intf) begin
        intf_d = hwdata[9:0];
        intf_d[device_reset_bit] = 1'b0;
        intf_d[overflow_or_fifo_clear] = 1'b0;
        intf_d[reserved_bit] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_q <= conversion_setup_rst;
      intf_q <= interface_setup_rst;
    end else begin
      conv_q <= conv_d;
      intf_q <= intf_d;
    end
  end

  assign code = conv_q[autoscan_bit:channel_pick_lo];

  scan_sequencer u_seq (
    .core_clk(core_clk),
    .resetn(resetn),
    .config_code(code),
    .conv_step(conv_done && store_q),
    .restart(restart_seq),
    .source(seq_source),
    .position(seq_pos),
    .reserved_code(seq_bad)
  );

  // Hold off storing for five clocks after a device reset.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) hold_q <= 3'h0;
    else if (dev_reset) hold_q <= first_result_cnt;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end

  // Clear strobes for FIFO pointer and offset; the clear bit pulses too.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_clear_q <= 1'b0;
      offset_clear_q <= 1'b0;
    end else begin
      fifo_clear_q <= dev_reset || (wr_intf && hwdata[overflow_or_fifo_clear]);
      offset_clear_q <= dev_reset;
    end
  end

  // Results ready: static level or single pulse per level crossing.
  assign ready_level = fifo_level_hit && (conv_q[selftest_pick_hi:selftest_pick_lo] == test_normal);
  assign ready_pulse = ready_level && !ready_seen_q;
  assign ready_pin = (intf_q[ready_type_bit] ? ready_pulse : ready_level)
                     ^ !intf_q[ready_polarity_bit];

  // Outputs are registered; test mode blanks the ready indication.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      store_q <= 1'b0;
      ready_q <= 1'b0;
      ready_seen_q <= 1'b0;
      sel_q <= src_none;
      test_q <= test_normal;
    end else begin
      store_q <= (hold_q <= 3'h1) && !dev_reset && !seq_bad && !conv_q[powerdown_bit];
      ready_seen_q <= ready_level;
      ready_q <= ready_pin;
      sel_q <= seq_bad ? src_none : seq_source;
      test_q <= conv_q[selftest_pick_hi:selftest_pick_lo];
    end
  end

  // Read mux; the two setup registers are write only and read as zero.
  assign rd_value = ((haddr & addr_mask) == selection_status_addr)
                    ? {25'h0, seq_bad, seq_pos, seq_source, hold_q != 3'h0} : 32'h0;

  // Read data is captured at the address phase so hrdata comes from a flop.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) hrdata_q <= 32'h0;
    else if (addr_phase && !hwrite) hrdata_q <= rd_value;
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign input_select = sel_q;
  assign test_select = test_q;
  assign conversion_setup = conv_q;
  assign interface_setup = intf_q;
  assign fifo_clear = fifo_clear_q;
  assign offset_clear = offset_clear_q;
  assign store_enable = store_q;
  assign results_ready = ready_q;
endmodule

// ---- tb/scan_select_properties.sv ----
// Checker for the input selection block, watching its top ports only.
// Assumes one clock domain; the bind stands after the module.
`timescale 1ns/1ps
module scan_select_properties
  import scan_select_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic resetn, // Reset, active low.
  input wire logic conv_done, // Conversion pulse.
  input scan_select_pkg::source_e input_select, // Source in use.
  input wire logic [1:0] test_select, // Test code.
  input wire logic [9:0] conversion_setup, // First register.
  input wire logic [9:0] interface_setup, // Second register.
  input wire logic fifo_clear, // FIFO clear pulse.
  input wire logic offset_clear, // Offset clear pulse.
  input wire logic store_enable, // Storing allowed.
  input wire logic results_ready // Ready indication.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Codes outside this set are reserved and must park the selector.
  wire logic [4:0] cfg = conversion_setup[7:3];
  wire logic legal = cfg inside {[5'h00:5'h05], 5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
  // Two quiet edges, so the registered selector has caught up.
  sequence settled;
    $stable(conversion_setup)[*2];
  endsequence
  sequence held_off;
    (fifo_clear && !store_enable) ##1 !store_enable[*3];
  endsequence
  single_pick_a: assert property (
    settled ##0 (cfg[4:2] == 3'h0) |-> input_select == source_e'({1'b0, cfg[1:0]}))
    else $error("single input wrong");
  diff_pick_a: assert property (
    settled ##0 (cfg[4:1] == 4'h2) |-> input_select == (cfg[0] ? src_b_diff : src_a_diff))
    else $error("pair input wrong");
  reserved_park_a: assert property (
    settled ##0 !legal |-> input_select == src_none && !store_enable)
    else $error("reserved code not parked");
  test_follow_a: assert property (
    settled |-> test_select == conversion_setup[9:8])
    else $error("test code wrong");
  test_quiet_a: assert property (
    (test_select != 2'h0 && $stable(interface_setup))[*2] |-> results_ready == !interface_setup[5])
    else $error("ready shown in test mode");
  scan_step_a: assert property (
    settled ##0 (cfg == 5'h11 && conv_done && store_enable && input_select == src_a_pos)
    |-> ##[1:2] input_select == src_a_neg)
    else $error("scan did not advance");
  reset_default_a: assert property (
    offset_clear |-> conversion_setup == conversion_setup_rst && interface_setup == interface_setup_rst)
    else $error("defaults not restored");
  reset_hold_a: assert property ($rose(offset_clear) |-> held_off)
    else $error("store not held off");
  clear_pulse_a: assert property (fifo_clear |=> !fifo_clear)
    else $error("clear pulse too long");
endmodule
bind adc_input_scan_select scan_select_properties i_scan_select_properties (.core_clk,
  .resetn, .conv_done, .input_select, .test_select, .conversion_setup, .interface_setup,
  .fifo_clear, .offset_clear, .store_enable, .results_ready);

// ---- tb/host_master.sv ----
// Host model: single word transfers on the register port.
// Assumes one slave whose hreadyout comes back on hready.
`timescale 1ns/1ps
module host_master
  import scan_select_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hrdata, // Read data.
  output logic hsel, // Slave select.
  output logic [7:0] haddr, // Byte address.
  output logic [1:0] htrans, // Transfer type.
  output logic hwrite, // Write flag.
  output logic [2:0] hsize, // Transfer size.
  output logic [31:0] hwdata // Write data.
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = hsize_word;
    hwdata = 32'h0;
  end
  // Address phase held until ready, then data phase held until ready.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= htrans_nonseq;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
    // A released bus shows the inverse, so stale data never looks valid.
    hwdata <= ~d;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Bench for the input selection block: register access, scans, tests.
// Assumes the host model drives the bus and the checker is bound.
`timescale 1ns/1ps
module tb_top;
  import scan_select_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_done = 1'b0;
  logic fifo_level_hit = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, fifo_clear, offset_clear, store_enable, results_ready;
  logic [7:0] haddr;
  logic [1:0] htrans, test_select;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [9:0] conversion_setup, interface_setup;
  logic [27:0] t;
  source_e input_select;
  int n_fail = 0;
  int samples_checked = 0;
  int n_fc = 0;
  int n_oc = 0;
  int n_low = 0;
  int b0, b1, b2;
  // Per legal code: code, length, then the sources in scan order.
  localparam logic [27:0] seq_tbl [12] = '{28'h00_1_0000, 28'h01_1_1000, 28'h02_1_2000,
    28'h03_1_3000, 28'h04_1_4000, 28'h05_1_5000, 28'h11_2_0100, 28'h12_3_0120,
    28'h13_4_0123, 28'h15_2_0500, 28'h16_3_0150, 28'h19_2_4500};
  always #50 core_clk = ~core_clk;
  adc_input_scan_select i_adc_input_scan_select (.core_clk, .resetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .conv_done,
    .fifo_level_hit, .input_select, .test_select, .conversion_setup, .interface_setup,
    .fifo_clear, .offset_clear, .store_enable, .results_ready);
  host_master i_host_master (.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);
  // Pulse and hold-off counters, sampled at each edge.
  always @(posedge core_clk) begin
    if (fifo_clear === 1'b1) n_fc++;
    if (offset_clear === 1'b1) n_oc++;
    if (store_enable === 1'b0) n_low++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host_master.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    i_host_master.xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog sized well past the whole sequence.
  initial begin
    #3000000;
    n_fail++;
    stop_test();
  end
  initial begin
    wt(5);
    resetn <= 1'b1;
    wt(2);
    chk(32'(conversion_setup), 32'h020);
    chk(32'(interface_setup), 32'h030);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h0c, 32'h0);
    b0 = n_fc;
    b1 = n_oc;
    wr(8'h04, 32'h3fe);
    wt(3);
    chk(32'(interface_setup), 32'h1fc);
    chk(32'(n_fc - b0), 32'h1);
    chk(32'(n_oc - b1), 32'h0);
    fifo_level_hit <= 1'b1;
    wr(8'h04, 32'h20);
    wt(3);
    chk(32'(results_ready), 32'h1);
    // Host checks each reference source; readiness must stay quiet.
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 32'h020 | (32'(m) << 8));
      wt(3);
      chk(32'(test_select), 32'(m));
      chk(32'(results_ready), 32'h0);
    end
    b0 = n_fc;
    b1 = n_oc;
    b2 = n_low;
    wr(8'h04, 32'h1);
    wt(10);
    chk(32'(n_low - b2), 32'h5);
    chk(32'(n_fc - b0), 32'h1);
    chk(32'(n_oc - b1), 32'h1);
    chk(32'(test_select), 32'h0);
    chk(32'(interface_setup), 32'h030);
    // Every code, reserved ones too; scans run past a wrap so a rewrite must restart.
    for (int c = 0; c < 32; c++) begin
      t = 28'h0;
      foreach (seq_tbl[i]) if (seq_tbl[i][27:20] == 8'(c)) t = seq_tbl[i];
      wr(8'h00, 32'(c) << 3);
      wt(3);
      if (t[19:16] == 4'h0) begin
        chk(32'(input_select), 32'(src_none));
        chk(32'(store_enable), 32'h0);
      end
      for (int s = 0; t[19:16] != 4'h0 && s <= 2 * t[19:16]; s++) begin
        chk(32'(input_select), 32'(t[15 - 4 * (s % t[19:16]) -: 4]));
        conv_done <= 1'b1;
        wt(1);
        conv_done <= 1'b0;
        wt(3);
      end
    end
    // Power down must stop storing even with a legal selection.
    wr(8'h00, 32'h024);
    wt(3);
    chk(32'(store_enable), 32'h0);
    stop_test();
  end
endmodule
